// file: core/pnl_cfg.svh
// constants of the panel output path
`ifndef PNL_CFG_SVH
`define PNL_CFG_SVH
`define PNL_DIV_LAST  3'd6
`define PNL_DIV_ZERO  3'd0
`define PNL_DIV_ONE   3'd1
`define PNL_CLK_HI    3'd3
`define PNL_CLK_PAT   7'b1100011
`define PNL_CNT_ZERO  12'h000
`define PNL_STEP_ONE  12'h001
`define PNL_STEP_TWO  12'h002
`define PNL_DLY_ZERO  8'h00
`define PNL_DLY_ONE   8'h01
`define PNL_LFSR_SEED 16'hACE1
`define PNL_LFSR_TAPS 16'hB400
`define PNL_PIX_ZERO  8'h00
`define PNL_ODD_BASE  3'd4
`endif

// file: core/pnl_pkg.sv
// types of the panel output path
package pnl_pkg;
  typedef logic [11:0] pnl_cnt_t;
  typedef logic [6:0]  pnl_word_t;
  typedef enum logic [3:0] {
    PNL_OFF  = 4'b0001,
    PNL_UP   = 4'b0010,
    PNL_ON   = 4'b0100,
    PNL_DOWN = 4'b1000
  } pnl_seq_e;
endpackage

// file: core/pnl_dither.sv
// one colour channel reduced from 10 to 8 or 6 bits
`timescale 1ns/100ps
`include "pnl_cfg.svh"
module pnl_dither
  import pnl_pkg::*;
(
  // colour in
  input  wire logic [9:0] i_val,
  // mode
  input  wire logic       i_six,
  input  wire logic       i_ordered,
  // position, frame and noise
  input  wire logic [1:0] i_pos,
  input  wire logic [1:0] i_frame,
  input  wire logic [3:0] i_rnd,
  // colour out, six-bit results left aligned
  output logic      [7:0] o_val
);
  logic [1:0] bay;
  logic [3:0] thr;
  logic       up;
  logic [6:0] sum6;
  logic [8:0] sum8;

  always_comb begin
    // bayer cell turned every frame spreads the error in time too
    bay  = {i_pos[0] ^ i_pos[1], i_pos[1]} ^ i_frame;
    thr  = i_ordered ? {bay, i_frame ^ i_pos} : i_rnd;
    up   = i_six ? (i_val[3:0] > thr) : (i_val[1:0] > thr[3:2]);
    sum6 = {1'b0, i_val[9:4]} + {6'h00, up};
    sum8 = {1'b0, i_val[9:2]} + {8'h00, up};
    // saturate so full white never wraps to black
    if (i_six) begin
      o_val = sum6[6] ? 8'hFC : {sum6[5:0], 2'b00};
    end else begin
      o_val = sum8[8] ? 8'hFF : sum8[7:0];
    end
  end
endmodule

// file: core/pnl_lvds_ser.sv
// one lvds data channel, seven slots per pixel clock
`timescale 1ns/100ps
`include "pnl_cfg.svh"
module pnl_lvds_ser
  import pnl_pkg::*;
(
  // clock and reset
  input  wire logic      i_clk,
  input  wire logic      i_rst,
  // word and control
  input  wire logic      i_load,
  input  wire logic      i_enable,
  input  wire logic      i_invert,
  input  wire pnl_word_t i_word,
  // serial out
  output logic           o_bit
);
  pnl_word_t sh_ff;
  logic      bit_ff;

  // first listed slot goes out first
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sh_ff <= '0;
    end else if (i_load) begin
      sh_ff <= {i_word[5:0], 1'b0};
    end else begin
      sh_ff <= {sh_ff[5:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_ff <= 1'b0;
    end else if (!i_enable) begin
      bit_ff <= 1'b0;
    end else begin
      bit_ff <= (i_load ? i_word[6] : sh_ff[6]) ^ i_invert;
    end
  end

  assign o_bit = bit_ff;

  property p_first_slot;
    @(posedge i_clk) disable iff (i_rst)
    i_load && i_enable |=> bit_ff == ($past(i_word[6]) ^ $past(i_invert));
  endproperty
  a_first_slot: assert property (p_first_slot) else $error("first slot wrong");
endmodule

// file: core/pnl_out.sv
// panel timing, power sequencing, dithering and dual lvds mapping
// Operation
// - 18 or 24 bit, one or two pixels
// - timing outputs change on the pixel clock edge
// - frame lock follows input frame rate
// - free run uses programmed values only
// - syncs and enable made from settings, to lvds
// - horizontal counts pixels from hsync lead edge
// - vertical counts lines from vsync lead edge
// - power and bias outputs, programmable timing
// - dither ten bits to eight or six
// - random or ordered, spatial and temporal
// - two groups of four channels, single/double
// - even and odd groups may swap
// - data channels reorder, clocks stay fixed
// - each channel polarity may invert
// - first 24 bit map, low bits first
// - second 24 bit map, high bits first
// - 18 bit uses second map, channel 3 off
// - channel 2 ends hsync, vsync, enable
// - fast enough for sxga at 75 hz
`timescale 1ns/100ps
`include "pnl_cfg.svh"
module pnl_out
  import pnl_pkg::*;
(
  // clock and reset
  input  wire logic       I_MCLK,
  input  wire logic       I_RST,
  // mode
  input  wire logic       I_FREE_RUN,
  input  wire logic       I_PANEL_24BIT,
  input  wire logic       I_DOUBLE_PIXEL,
  input  wire logic       I_MAP_HIGH,
  input  wire logic       I_DITHER_ORDERED,
  // lvds steering
  input  wire logic       I_EVEN_ODD_SWAP,
  input  wire logic [7:0] I_CHAN_MAP,
  input  wire logic [7:0] I_CHAN_INVERT,
  // horizontal settings in pixels
  input  wire pnl_cnt_t   I_H_TOTAL,
  input  wire pnl_cnt_t   I_H_SYNC_W,
  input  wire pnl_cnt_t   I_H_DE_START,
  input  wire pnl_cnt_t   I_H_DE_END,
  // vertical settings in lines
  input  wire pnl_cnt_t   I_V_TOTAL,
  input  wire pnl_cnt_t   I_V_SYNC_W,
  input  wire pnl_cnt_t   I_V_DE_START,
  input  wire pnl_cnt_t   I_V_DE_END,
  // power sequencing
  input  wire logic       I_PANEL_ON,
  input  wire logic [7:0] I_SEQ_DELAY,
  // input frame reference
  input  wire logic       I_SRC_VSYNC,
  // pixel source
  input  wire logic [9:0] I_PIX0_R,
  input  wire logic [9:0] I_PIX0_G,
  input  wire logic [9:0] I_PIX0_B,
  input  wire logic [9:0] I_PIX1_R,
  input  wire logic [9:0] I_PIX1_G,
  input  wire logic [9:0] I_PIX1_B,
  output logic            O_PIX_REQ,
  // parallel display timing
  output logic            O_DISPLAY_PIXEL_CLOCK,
  output logic            O_DISPLAY_HSYNC_OUT,
  output logic            O_DISPLAY_VSYNC_OUT,
  output logic            O_DISPLAY_DATA_ENABLE_OUT,
  // panel power
  output logic            O_PANEL_POWER_CONTROL,
  output logic            O_PANEL_BIAS_CONTROL,
  // lvds
  output logic [7:0]      O_LVDS_DATA,
  output logic            O_LVDS_CLK_EVEN,
  output logic            O_LVDS_CLK_ODD
);
  logic [2:0]  phase_ff;
  logic        pclk_ff;
  logic        clk_ff;
  logic        strobe;
  logic [2:0]  nxt_phase;
  pnl_cnt_t    h_ff;
  pnl_cnt_t    v_ff;
  pnl_cnt_t    nxt_h;
  pnl_cnt_t    nxt_v;
  pnl_cnt_t    step;
  logic        hs_ff;
  logic        vs_ff;
  logic        de_ff;
  logic        nxt_de;
  logic        sv_s1_ff;
  logic        sv_s2_ff;
  logic        sv_s3_ff;
  logic        lock_ff;
  logic        frame_tick;
  logic [1:0]  frame_ff;
  logic [15:0] lfsr_ff;
  logic [9:0]  din [6];
  logic [7:0]  dth [6];
  logic [7:0]  dq_ff [6];
  pnl_word_t   lw [8];
  logic [7:0]  len;
  pnl_seq_e    seq_ff;
  logic [7:0]  dly_ff;
  logic        pwr_ff;
  logic        bias_ff;
  // a literal cannot be indexed, so the slot clock pattern gets a name
  localparam logic [6:0] clk_pat = `PNL_CLK_PAT;

  // pixel clock is the master clock divided by seven
  assign strobe    = (phase_ff == `PNL_DIV_LAST);
  assign nxt_phase = strobe ? `PNL_DIV_ZERO : phase_ff + `PNL_DIV_ONE;

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      phase_ff <= `PNL_DIV_ZERO;
      pclk_ff  <= 1'b0;
      clk_ff   <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      pclk_ff  <= (nxt_phase <= `PNL_CLK_HI);
      clk_ff   <= clk_pat[`PNL_DIV_LAST - nxt_phase];
    end
  end

  // input vsync is foreign: two stages before any edge logic
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      sv_s1_ff <= 1'b0;
      sv_s2_ff <= 1'b0;
      sv_s3_ff <= 1'b0;
    end else begin
      sv_s1_ff <= I_SRC_VSYNC;
      sv_s2_ff <= sv_s1_ff;
      sv_s3_ff <= sv_s2_ff;
    end
  end

  // an input frame start arriving on the consuming strobe is kept
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      lock_ff <= 1'b0;
    end else if (sv_s2_ff && !sv_s3_ff) begin
      lock_ff <= 1'b1;
    end else if (strobe) begin
      lock_ff <= 1'b0;
    end
  end

  // double mode advances two pixels per clock; odd totals unsupported
  assign step = I_DOUBLE_PIXEL ? `PNL_STEP_TWO : `PNL_STEP_ONE;

  // 12 bit counters cover sxga totals with margin
  always_comb begin
    nxt_h = h_ff + step;
    nxt_v = v_ff;
    if (nxt_h >= I_H_TOTAL) begin
      nxt_h = `PNL_CNT_ZERO;
      nxt_v = v_ff + `PNL_STEP_ONE;
      if (nxt_v >= I_V_TOTAL) begin
        nxt_v = `PNL_CNT_ZERO;
      end
    end
    if (lock_ff && !I_FREE_RUN) begin
      nxt_h = `PNL_CNT_ZERO;
      nxt_v = `PNL_CNT_ZERO;
    end
  end

  assign nxt_de = (nxt_h >= I_H_DE_START) && (nxt_h < I_H_DE_END) &&
                  (nxt_v >= I_V_DE_START) && (nxt_v < I_V_DE_END);
  assign frame_tick = strobe && (nxt_h == `PNL_CNT_ZERO) &&
                      (nxt_v == `PNL_CNT_ZERO);

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      h_ff <= `PNL_CNT_ZERO;
      v_ff <= `PNL_CNT_ZERO;
    end else if (strobe) begin
      h_ff <= nxt_h;
      v_ff <= nxt_v;
    end
  end

  // timing outputs move only on the rising pixel clock edge
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      hs_ff <= 1'b0;
      vs_ff <= 1'b0;
      de_ff <= 1'b0;
    end else if (strobe) begin
      hs_ff <= nxt_h < I_H_SYNC_W;
      vs_ff <= nxt_v < I_V_SYNC_W;
      de_ff <= nxt_de;
    end
  end

  // frame count and noise feed the temporal part of dithering
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      frame_ff <= 2'b00;
      lfsr_ff  <= `PNL_LFSR_SEED;
    end else begin
      frame_ff <= frame_ff + {1'b0, frame_tick};
      lfsr_ff  <= {1'b0, lfsr_ff[15:1]} ^ (lfsr_ff[0] ? `PNL_LFSR_TAPS : 16'h0000);
    end
  end

  assign O_PIX_REQ = strobe && nxt_de;

  assign din[0] = I_PIX0_R;
  assign din[1] = I_PIX0_G;
  assign din[2] = I_PIX0_B;
  assign din[3] = I_PIX1_R;
  assign din[4] = I_PIX1_G;
  assign din[5] = I_PIX1_B;

  for (genvar k = 0; k < 6; k++) begin : g_dith
    pnl_dither u_dith (
      .i_val     (din[k]),
      .i_six     (!I_PANEL_24BIT),
      .i_ordered (I_DITHER_ORDERED),
      .i_pos     ({nxt_v[0], nxt_h[0] ^ (k >= 3)}),
      .i_frame   (frame_ff),
      .i_rnd     (lfsr_ff[2*k +: 4]),
      .o_val     (dth[k])
    );

    always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
        dq_ff[k] <= `PNL_PIX_ZERO;
      end else if (strobe) begin
        dq_ff[k] <= O_PIX_REQ ? dth[k] : `PNL_PIX_ZERO;
      end
    end
  end

  // slot order per channel, first listed slot in bit 6
  function automatic logic [27:0] map_px(input logic [7:0] r, input logic [7:0] g,
                                         input logic [7:0] b, input logic hi);
    logic [5:0] cr;
    logic [5:0] cg;
    logic [5:0] cb;
    logic [1:0] er;
    logic [1:0] eg;
    logic [1:0] eb;
    cr = hi ? r[7:2] : r[5:0];
    cg = hi ? g[7:2] : g[5:0];
    cb = hi ? b[7:2] : b[5:0];
    er = hi ? r[1:0] : r[7:6];
    eg = hi ? g[1:0] : g[7:6];
    eb = hi ? b[1:0] : b[7:6];
    map_px[6:0]   = {cr[0], cr[1], cr[2], cr[3], cr[4], cr[5], cg[0]};
    map_px[13:7]  = {cg[1], cg[2], cg[3], cg[4], cg[5], cb[0], cb[1]};
    map_px[20:14] = {cb[2], cb[3], cb[4], cb[5], 3'b000};
    map_px[27:21] = {er[0], er[1], eg[0], eg[1], eb[0], eb[1], 1'b0};
  endfunction

  // six bit panel data sits in the high bits, so 18 bit uses the high pick
  logic        hi_pick;
  logic [27:0] wp [2];
  assign hi_pick = I_MAP_HIGH || !I_PANEL_24BIT;

  always_comb begin
    wp[0] = map_px(dq_ff[0], dq_ff[1], dq_ff[2], hi_pick);
    wp[1] = map_px(dq_ff[3], dq_ff[4], dq_ff[5], hi_pick);
    wp[0][16:14] = {hs_ff, vs_ff, de_ff};
    wp[1][16:14] = {hs_ff, vs_ff, de_ff};
  end

  // logical channels: 0..3 even group, 4..7 odd group
  for (genvar j = 0; j < 8; j++) begin : g_log
    assign lw[j]  = wp[(j >= 4) ^ I_EVEN_ODD_SWAP][7*(j%4) +: 7];
    assign len[j] = ((j % 4) != 3 || I_PANEL_24BIT) &&
                    (j < 4 || I_DOUBLE_PIXEL);
  end

  // each physical lane picks a logical channel within its own group
  for (genvar p = 0; p < 8; p++) begin : g_lane
    logic [2:0] src;
    assign src = {p >= 4, I_CHAN_MAP[2*(p%4) +: 2]};

    pnl_lvds_ser u_ser (
      .i_clk    (I_MCLK),
      .i_rst    (I_RST),
      .i_load   (strobe),
      .i_enable (len[src]),
      .i_invert (I_CHAN_INVERT[p]),
      .i_word   (lw[src]),
      .o_bit    (O_LVDS_DATA[p])
    );
  end

  // power first, bias after the delay; reverse order on the way down
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      seq_ff  <= PNL_OFF;
      dly_ff  <= `PNL_DLY_ZERO;
      pwr_ff  <= 1'b0;
      bias_ff <= 1'b0;
    end else begin
      case (seq_ff)
        PNL_OFF: begin
          if (I_PANEL_ON) begin
            seq_ff <= PNL_UP;
            dly_ff <= I_SEQ_DELAY;
            pwr_ff <= 1'b1;
          end
        end
        PNL_UP: begin
          if (!I_PANEL_ON) begin
            seq_ff <= PNL_OFF;
            pwr_ff <= 1'b0;
          end else if (dly_ff == `PNL_DLY_ZERO) begin
            seq_ff  <= PNL_ON;
            bias_ff <= 1'b1;
          end else if (frame_tick) begin
            dly_ff <= dly_ff - `PNL_DLY_ONE;
          end
        end
        PNL_ON: begin
          if (!I_PANEL_ON) begin
            seq_ff  <= PNL_DOWN;
            dly_ff  <= I_SEQ_DELAY;
            bias_ff <= 1'b0;
          end
        end
        PNL_DOWN: begin
          if (dly_ff == `PNL_DLY_ZERO) begin
            seq_ff <= PNL_OFF;
            pwr_ff <= 1'b0;
          end else if (frame_tick) begin
            dly_ff <= dly_ff - `PNL_DLY_ONE;
          end
        end
        default: begin
          seq_ff  <= PNL_OFF;
          pwr_ff  <= 1'b0;
          bias_ff <= 1'b0;
        end
      endcase
    end
  end

  assign O_DISPLAY_PIXEL_CLOCK     = pclk_ff;
  assign O_DISPLAY_HSYNC_OUT       = hs_ff;
  assign O_DISPLAY_VSYNC_OUT       = vs_ff;
  assign O_DISPLAY_DATA_ENABLE_OUT = de_ff;
  assign O_PANEL_POWER_CONTROL     = pwr_ff;
  assign O_PANEL_BIAS_CONTROL      = bias_ff;
  assign O_LVDS_CLK_EVEN           = clk_ff;
  assign O_LVDS_CLK_ODD            = clk_ff && I_DOUBLE_PIXEL;

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);

  sequence s_clk_hi;
    pclk_ff [*4];
  endsequence
  sequence s_clk_lo;
    !pclk_ff [*3];
  endsequence

  property p_pclk_shape;
    strobe |=> s_clk_hi ##1 s_clk_lo;
  endproperty
  a_pclk_shape: assert property (p_pclk_shape) else $error("pixel clock shape");

  property p_sync_edge;
    $changed(de_ff) || $changed(hs_ff) || $changed(vs_ff) |-> $rose(pclk_ff);
  endproperty
  a_sync_edge: assert property (p_sync_edge) else $error("timing off clock edge");

  property p_lock;
    strobe && lock_ff && !I_FREE_RUN |=> h_ff == `PNL_CNT_ZERO && v_ff == `PNL_CNT_ZERO;
  endproperty
  a_lock: assert property (p_lock) else $error("frame lock missed");

  property p_free_wrap;
    strobe && I_FREE_RUN && (h_ff + step >= I_H_TOTAL) |=> h_ff == `PNL_CNT_ZERO;
  endproperty
  a_free_wrap: assert property (p_free_wrap) else $error("line did not wrap");

  property p_hsync;
    strobe |=> hs_ff == (h_ff < I_H_SYNC_W);
  endproperty
  a_hsync: assert property (p_hsync) else $error("hsync width wrong");

  property p_vsync;
    strobe |=> vs_ff == (v_ff < I_V_SYNC_W);
  endproperty
  a_vsync: assert property (p_vsync) else $error("vsync width wrong");

  property p_de_req;
    O_PIX_REQ |=> de_ff ##1 de_ff [*6];
  endproperty
  a_de_req: assert property (p_de_req) else $error("enable not held");

  property p_bias_order;
    $rose(bias_ff) |-> pwr_ff && $past(pwr_ff);
  endproperty
  a_bias_order: assert property (p_bias_order) else $error("bias before power");

  property p_pwr_order;
    $fell(pwr_ff) |-> !bias_ff;
  endproperty
  a_pwr_order: assert property (p_pwr_order) else $error("power off under bias");
endmodule

// file: bench/pnl_panel_model.sv
// lcd panel model that deframes the eight lvds lanes
`timescale 1ns/100ps
module pnl_panel_model (
  // slot clock and link
  input  wire logic        i_clk,
  input  wire logic        i_lclk,
  input  wire logic [7:0]  i_data,
  // received words, lane p at [7*p+:7]
  output logic      [55:0] o_words,
  output logic             o_valid
);
  logic [6:0] csr;
  logic [6:0] sr [8];
  int         p;

  initial begin
    csr = 7'h00;
    o_valid = 1'h0;
  end

  // mid-slot sampling stays clear of the sender's edge
  always @(negedge i_clk) begin
    csr = {csr[5:0], i_lclk};
    for (p = 0; p < 8; p++) begin
      sr[p] = {sr[p][5:0], i_data[p]};
      // clock pattern 1100011 closes a word, first slot ends up on top
      if (csr == 7'h63) begin
        o_words[7*p +: 7] = sr[p];
      end
    end
    o_valid = (csr == 7'h63);
  end
endmodule

// file: bench/pnl_out_tb.sv
// self-checking bench of the panel output path
`timescale 1ns/100ps
module pnl_out_tb;
  import pnl_pkg::*;
  typedef struct packed {
    logic        p24;
    logic        hi;
    logic        dbl;
    logic        swp;
    logic        ord;
    logic [7:0]  cmap;
    logic [7:0]  inv;
    logic [23:0] px0;
    logic [23:0] px1;
  } pnl_row_s;
  logic        mclk, rst, free, p24, dbl, hi, ord, swp, on, svs, son;
  logic [7:0]  cmap, inv, dly, lvds;
  logic [9:0]  r0, g0, b0, r1, g1, b1;
  logic        req, pclk, hs, vs, de, pwr, bias, ce, co, pv, pq, dq, armed, pr;
  pnl_cnt_t    ht, hw, hs0, he, vt, vw, vs0, ve;
  logic [55:0] pw, m;
  logic [2:0]  sq;
  pnl_row_s    rows [8];
  int          n_mismatch, compares, k, ones, run;

  pnl_out DUT (.I_MCLK(mclk), .I_RST(rst), .I_FREE_RUN(free), .I_PANEL_24BIT(p24), .I_DOUBLE_PIXEL(dbl),
    .I_MAP_HIGH(hi), .I_DITHER_ORDERED(ord), .I_EVEN_ODD_SWAP(swp), .I_CHAN_MAP(cmap), .I_CHAN_INVERT(inv),
    .I_H_TOTAL(ht), .I_H_SYNC_W(hw), .I_H_DE_START(hs0), .I_H_DE_END(he), .I_V_TOTAL(vt), .I_V_SYNC_W(vw),
    .I_V_DE_START(vs0), .I_V_DE_END(ve), .I_PANEL_ON(on), .I_SEQ_DELAY(dly), .I_SRC_VSYNC(svs),
    .I_PIX0_R(r0), .I_PIX0_G(g0), .I_PIX0_B(b0), .I_PIX1_R(r1), .I_PIX1_G(g1), .I_PIX1_B(b1), .O_PIX_REQ(req),
    .O_DISPLAY_PIXEL_CLOCK(pclk), .O_DISPLAY_HSYNC_OUT(hs), .O_DISPLAY_VSYNC_OUT(vs),
    .O_DISPLAY_DATA_ENABLE_OUT(de), .O_PANEL_POWER_CONTROL(pwr), .O_PANEL_BIAS_CONTROL(bias),
    .O_LVDS_DATA(lvds), .O_LVDS_CLK_EVEN(ce), .O_LVDS_CLK_ODD(co));
  pnl_panel_model PANEL (.i_clk(mclk), .i_lclk(ce), .i_data(lvds), .o_words(pw), .o_valid(pv));

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // source frame reference, toggles only while son is set
  initial begin
    svs = 1'h0;
    forever #80 svs = son & ~svs;
  end

  task automatic check(input logic [55:0] seen, input logic [55:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic prise();
    logic was;
    for (int i = 0; i < 16; i++) begin
      was = pclk;
      tick(1);
      if (pclk && !was) break;
    end
  endtask
  // six-bit panels read the top six bits of the dithered value
  function automatic logic [27:0] words(input logic p, input logic h, input logic [23:0] c);
    logic [7:0] r, g, b;
    logic [6:0] c3;
    r = (p && !h) ? c[23:16] : {2'h0, c[23:18]};
    g = (p && !h) ? c[15:8] : {2'h0, c[15:10]};
    b = (p && !h) ? c[7:0] : {2'h0, c[7:2]};
    c3 = !p ? 7'h00 : h ? {c[16], c[17], c[8], c[9], c[0], c[1], 1'h0} : {c[22], c[23], c[14], c[15], c[6], c[7], 1'h0};
    return {c3, b[2], b[3], b[4], b[5], 3'h1, g[1], g[2], g[3], g[4], g[5], b[0], b[1],
            r[0], r[1], r[2], r[3], r[4], r[5], g[0]};
  endfunction
  function automatic logic [55:0] lanes(input pnl_row_s w);
    logic [27:0] src;
    logic [1:0]  ch;
    lanes = 56'h0;
    for (int p = 0; p < 8; p++) begin
      src = words(w.p24, w.hi, ((p > 3) ^ w.swp) ? w.px1 : w.px0);
      ch = w.cmap[2*(p%4) +: 2];
      lanes[7*p +: 7] = (!w.p24 && ch == 2'h3) ? 7'h00 : src[7*ch +: 7] ^ {7{w.inv[p]}};
    end
  endfunction
  // waits for a received word of an active pixel
  task automatic get_word();
    int q;
    for (q = 0; q < 3; q++) begin
      if (cmap[2*q +: 2] == 2'h2) break;
    end
    for (int i = 0; i < 400; i++) begin
      tick(1);
      if (pv && (pw[7*q] ^ inv[q])) break;
    end
    check(pv && (pw[7*q] ^ inv[q]), 1'h1, "no active word");
  endtask
  task automatic frame_chk(input int step);
    int   h, v;
    logic was;
    was = 1'h1;
    for (int i = 0; i < 80; i++) begin
      prise();
      if (vs && !was) break;
      was = vs;
    end
    h = 0;
    v = 0;
    for (int i = 0; i < 32 / step; i++) begin
      check({hs, vs, de}, {h < hw, v < vw, h >= hs0 && h < he && v >= vs0 && v < ve}, "sync");
      h += step;
      if (h >= ht) begin
        h = 0;
        v = (v + 1) % vt;
      end
      prise();
    end
  endtask

  // syncs move only with the pixel clock rise, clock high 4 and low 3
  always @(posedge mclk) begin
    #2;
    dq = dbl;
    if (rst) begin
      armed = 1'h0;
      run = 0;
    end else begin
      run++;
      if (!(pclk && !pq)) check({hs, vs, de}, sq, "sync moved");
      check(co, ce & dq, "odd clock");
      check(pr, pclk && !pq && de, "pixel request");
      if (pclk !== pq) begin
        if (armed) check(run, pclk ? 3 : 4, "pixel clock");
        // first high phase after reset is one cycle short, so arm on the first fall
        armed = armed | !pclk;
        run = 0;
      end
    end
    pq = pclk;
    pr = req;
    sq = {hs, vs, de};
  end

  initial begin
    {rst, son, free, p24, dbl, hi, ord, swp, on} = 9'h164;
    {cmap, inv, dly} = 24'hE40002;
    {ht, hw, hs0, he} = {12'h008, 12'h001, 12'h002, 12'h007};
    {vt, vw, vs0, ve} = {12'h004, 12'h001, 12'h001, 12'h003};
    {r0, g0, b0, r1, g1, b1} = 60'h0;
    rows = '{
      '{1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 8'hE4, 8'h00, 24'h5A3CC9, 24'h000000},
      '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 8'hE4, 8'h00, 24'h5A3CC9, 24'h000000},
      '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 8'hE4, 8'h00, 24'hA45C38, 24'h000000},
      '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'hE4, 8'h00, 24'hC8F404, 24'h000000},
      '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 8'hE4, 8'h00, 24'h5A3CC9, 24'h81E736},
      '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 8'hE4, 8'h00, 24'h5A3CC9, 24'h81E736},
      '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 8'h1B, 8'hA5, 24'h96C3E1, 24'h2D784B},
      '{1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 8'h1B, 8'h0F, 24'hA45C38, 24'hC8F404}};
    tick(5);
    check({pclk, hs, vs, de, pwr, bias, lvds, ce, co, req}, 56'h0, "reset");
    tick(5);
    rst = 1'h0;
    tick(1);
    check(pclk, 1'h1, "first pixel clock");
    frame_chk(1);
    dbl = 1'h1;
    frame_chk(2);
    // colour values keep their low bits clear so dithering is exact
    for (k = 0; k < 8; k++) begin
      {p24, hi, dbl, swp, ord, cmap, inv} = rows[k][68:48];
      {r0, g0, b0} = {rows[k].px0[23:16], 2'h0, rows[k].px0[15:8], 2'h0, rows[k].px0[7:0], 2'h0};
      {r1, g1, b1} = {rows[k].px1[23:16], 2'h0, rows[k].px1[15:8], 2'h0, rows[k].px1[7:0], 2'h0};
      m = dbl ? 56'hFFFFFFFFFFFFFF : 56'h0000000FFFFFFF;
      tick(40);
      get_word();
      check(pw & m, lanes(rows[k]) & m, "lanes");
    end
    // half a step below eight bits must spread over pixels and frames
    for (k = 0; k < 2; k++) begin
      {p24, hi, dbl, swp, ord, cmap, inv} = {4'h8, k[0], 8'hE4, 8'h00};
      {r0, g0, b0} = {10'h002, 10'h000, 10'h000};
      ones = 0;
      tick(40);
      repeat (16) begin
        get_word();
        ones += pw[6];
      end
      check(ones > 0 && ones < 16, 1'h1, "dither spread");
    end
    free = 1'h0;
    son = 1'h1;
    tick(100);
    ones = 0;
    repeat (30) begin
      prise();
      ones += !vs;
    end
    check(ones, 0, "locked frame");
    free = 1'h1;
    ones = 0;
    repeat (40) begin
      prise();
      ones += !vs;
    end
    check(ones > 0, 1'h1, "free run");
    son = 1'h0;
    // one frame is 32 pixels of 7 cycles
    on = 1'h1;
    tick(1);
    check({pwr, bias}, 2'h2, "power first");
    for (k = 0; k < 600 && !bias; k++) tick(1);
    check(k >= 220 && k <= 460, 1'h1, "bias delay");
    on = 1'h0;
    tick(1);
    check({pwr, bias}, 2'h2, "bias off first");
    for (k = 0; k < 600 && pwr; k++) tick(1);
    check(k >= 220 && k <= 460, 1'h1, "power delay");
    on = 1'h1;
    tick(50);
    on = 1'h0;
    tick(1);
    check({pwr, bias}, 2'h0, "abort");
    dly = 8'h00;
    on = 1'h1;
    tick(2);
    check({pwr, bias}, 2'h3, "no delay");
    rst = 1'h1;
    tick(3);
    check({pclk, hs, vs, de, pwr, bias, lvds, ce, co, req}, 56'h0, "mid reset");
    rst = 1'h0;
    tick(1);
    check(pclk, 1'h1, "restart");
    test_done();
  end
  // the whole run needs under 10000 cycles
  initial begin
    #400000;
    n_mismatch++;
    test_done();
  end
endmodule
